// >>> rtl/power_stage_pkg.sv
// power_stage_pkg: register map, field positions, reset values and timing constants
// assumes one 100 MHz system clock and byte-wide registers
package power_stage_pkg;

    localparam logic [7:0] SYSTEM_CONTROL_ADDR      = 8'h03;
    localparam logic [7:0] POWER_OUTPUT_ADDR        = 8'h0b;
    localparam logic [7:0] SINK_LIMIT_ADDR          = 8'h02;
    localparam logic [7:0] GUARD_TIMER_CONTROL_ADDR = 8'h0a;
    localparam logic [7:0] SYSTEM_STATUS_ADDR       = 8'h0c;

    localparam logic [7:0] REG_RESET = 8'h00;

    // system control fields
    localparam int PSE_BIT   = 7;
    localparam int SLEWH_BIT = 6;
    localparam int SLEWL_BIT = 5;
    localparam int STOP_BIT  = 0;
    // power output field
    localparam int SWON_BIT  = 1;
    // sink limit field
    localparam int LIM_LSB   = 0;
    // guard timer control fields
    localparam int GRST_BIT  = 5;
    localparam int GRE_BIT   = 4;
    localparam int GIE_BIT   = 3;
    localparam int GRATE_BIT = 0;
    // status fields
    localparam int LINL_BIT  = 6;
    localparam int SWOC_BIT  = 5;
    localparam int LV_BIT    = 3;
    localparam int HV_BIT    = 2;
    localparam int BROC_BIT  = 1;
    localparam int OT_BIT    = 0;

    // guard timer periods
    localparam int CLK_MHZ        = 100;
    localparam int FAST_PERIOD_MS = 10;
    localparam int SLOW_PERIOD_MS = 20;
    localparam int FAST_CYCLES    = FAST_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int SLOW_CYCLES    = SLOW_PERIOD_MS * 1000 * CLK_MHZ;

    localparam logic [2:0] LIMIT_FIRST_CODE = 3'h3;

    typedef enum logic [2:0] {
        LIM_NONE,
        LIM_55MA,
        LIM_260MA,
        LIM_370MA,
        LIM_550MA,
        LIM_740MA
    } sink_limit_t;

    typedef enum logic [1:0] {
        SLEW_INITIAL_20K,
        SLEW_SLOW_10K,
        SLEW_FAST_8X,
        SLEW_FAST_4X
    } slew_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic lowVoltage;
        logic highVoltage;
        logic overTemp;
    } ifr_mirror_t;

endpackage

// >>> rtl/sink_limit_decode.sv
// sink_limit_decode: maps the three-bit limit code onto a named limit
// assumes a purely combinational use by the register bank
`timescale 1ns/1ps
module sink_limit_decode
(
    input  wire logic [2:0]                     code,
    output power_stage_pkg::sink_limit_t        limit
);
    wire logic [2:0] step = code - power_stage_pkg::LIMIT_FIRST_CODE;

    // codes below the first limit code mean no limit [RULE1]
    assign limit = (code < power_stage_pkg::LIMIT_FIRST_CODE)
                 ? power_stage_pkg::LIM_NONE
                 : power_stage_pkg::sink_limit_t'(step + 3'h1);
endmodule

// >>> rtl/guard_timer.sv
// guard_timer: timeout counter with restart, rate select and count-enable hold
// assumes restart is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module guard_timer
#(
    parameter int FAST_CYCLES = power_stage_pkg::FAST_CYCLES,
    parameter int SLOW_CYCLES = power_stage_pkg::SLOW_CYCLES
)
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic run,
    input  wire logic countEn,
    input  wire logic rateFast,
    input  wire logic restart,
    output logic      expire
);
    logic [31:0] count_reg;
    wire  logic [31:0] endValue = rateFast ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);
    wire  logic        atEnd    = count_reg >= endValue;

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !run || restart)
            count_reg <= 32'h0; // [RULE12] [RULE16]
        else if (countEn)
            count_reg <= atEnd ? 32'h0 : count_reg + 32'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            expire <= 1'b0;
        else
            expire <= run && countEn && atEnd && !restart;
    end
endmodule

// >>> rtl/power_stage_control.sv
// power_stage_control: register bank for power stage, lin slew, stop request and guard timer
// assumes a plain strobe port master; analog fault inputs synchronous to mclk
`timescale 1ns/1ps
//
// Operation
// RULE1: limit code 000-010 means no limit; 011-111 select 55..740 mA; reset clears.
// RULE2: switched supply output on only when power stage and supply-on both set.
// RULE3: supply over-temperature protection only with high-temperature reset enabled.
// RULE4: supply over-current turns output off and sets its status flag.
// RULE5: power stage enable bit 7 gates bridges, lin transmitter and supply.
// RULE6: two slew bits pick 20k, 10k, fast 8x or fast 4x rates.
// RULE7: writing stop request enters stop; cleared by reset or cpu interrupt.
// RULE8: read-only lin limiting bit follows transmitter current limiting.
// RULE9: write 1 clears supply over-current flag and re-enables; 0 ignored.
// RULE10: low, high voltage and overtemp status bits mirror interrupt flags.
// RULE11: write 1 clears bridge over-current flag and re-enables bridges.
// RULE12: guard timer runs only when reset or wake enable is set.
// RULE13: guard reset enable can be set once; only reset clears it.
// RULE14: in run mode timer end with reset enable asserts reset output.
// RULE15: guard reset function pauses in stop and resumes in run.
// RULE16: restart write restarts the timeout; restart bit reads zero.
// RULE17: wake enable wakes system periodically; interrupt only in stop mode.
// RULE18: rate bit set gives 10 ms, clear gives 20 ms; reset clears.
// RULE19: software writes zero to reserved guard control bit 2.
// RULE20: software copies clock trim byte to trim register after reset.
// RULE21: over-current flags stay set and outputs off until cleared or reset.
module power_stage_control
#(
    parameter int FAST_CYCLES = power_stage_pkg::FAST_CYCLES,
    parameter int SLOW_CYCLES = power_stage_pkg::SLOW_CYCLES
)
(
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire logic [7:0]                  addr,
    input  wire logic [7:0]                  wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [7:0]                  rdata,
    input  wire logic                        supplyOvercurrent,
    input  wire logic                        bridgeOvercurrent,
    input  wire logic                        supplyOvertemp,
    input  wire logic                        highTempResetEnable,
    input  wire logic                        linTxLimiting,
    input  wire logic                        lowVoltageFlag,
    input  wire logic                        highVoltageFlag,
    input  wire logic                        overtempFlag,
    input  wire logic                        cpuIrq,
    output logic                             switchedSupplyOutput,
    output logic                             bridgeEnable,
    output logic                             linTxEnable,
    output power_stage_pkg::sink_limit_t     sinkLimit,
    output power_stage_pkg::slew_t           linSlew,
    output logic                             stopMode,
    output logic                             guardOscRun,
    output logic                             guardResetOut,
    output logic                             guardWakeIrq
);
    logic       powerStageEnable_reg;
    logic [1:0] slewSelect_reg;
    logic       stopRequest_reg;
    logic       switchedSupplyOn_reg;
    logic [2:0] sinkLimitSelect_reg;
    logic       guardResetEnable_reg;
    logic       guardWakeEnable_reg;
    logic       guardRateSelect_reg;
    logic       supplyOcFlag_reg;
    logic       bridgeOcFlag_reg;
    power_stage_pkg::ifr_mirror_t mirror;
    power_stage_pkg::reg_req_t    req;
    power_stage_pkg::sink_limit_t limitDecoded;
    logic       guardExpire;

    assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    assign mirror = '{lowVoltage: lowVoltageFlag, highVoltage: highVoltageFlag,
                      overTemp: overtempFlag};

    // address decode
    wire logic wrCtl    = req.wr && req.addr == power_stage_pkg::SYSTEM_CONTROL_ADDR;
    wire logic wrPout   = req.wr && req.addr == power_stage_pkg::POWER_OUTPUT_ADDR;
    wire logic wrLimit  = req.wr && req.addr == power_stage_pkg::SINK_LIMIT_ADDR;
    wire logic wrGuard  = req.wr && req.addr == power_stage_pkg::GUARD_TIMER_CONTROL_ADDR;
    wire logic wrStatus = req.wr && req.addr == power_stage_pkg::SYSTEM_STATUS_ADDR;

    wire logic guardRestart = wrGuard && req.wdata[power_stage_pkg::GRST_BIT];       // [RULE16]
    wire logic stopSet      = wrCtl && req.wdata[power_stage_pkg::STOP_BIT];         // [RULE7]
    wire logic supplyOcClr  = wrStatus && req.wdata[power_stage_pkg::SWOC_BIT];      // [RULE9]
    wire logic bridgeOcClr  = wrStatus && req.wdata[power_stage_pkg::BROC_BIT];      // [RULE11]
    wire logic supplyFault  = supplyOvercurrent || (highTempResetEnable && supplyOvertemp); // [RULE3]
    wire logic guardCount   = guardResetEnable_reg || guardWakeEnable_reg;           // [RULE12]

    // status image: mirrors from the interrupt flags plus sticky flags
    wire logic [7:0] statusImage = {1'b0, linTxLimiting, supplyOcFlag_reg, 1'b0,
                                    mirror.lowVoltage, mirror.highVoltage,
                                    bridgeOcFlag_reg, mirror.overTemp}; // [RULE8] [RULE10]
    wire logic [7:0] ctlImage    = {powerStageEnable_reg, slewSelect_reg, 5'h00};
    wire logic [7:0] guardImage  = {3'h0, guardResetEnable_reg, guardWakeEnable_reg,
                                    2'h0, guardRateSelect_reg}; // [RULE16]
    wire logic [7:0] readMux =
        (req.addr == power_stage_pkg::SYSTEM_CONTROL_ADDR)      ? ctlImage :
        (req.addr == power_stage_pkg::POWER_OUTPUT_ADDR)        ? {6'h00, switchedSupplyOn_reg, 1'b0} :
        (req.addr == power_stage_pkg::SINK_LIMIT_ADDR)          ? {5'h00, sinkLimitSelect_reg} :
        (req.addr == power_stage_pkg::GUARD_TIMER_CONTROL_ADDR) ? guardImage :
        (req.addr == power_stage_pkg::SYSTEM_STATUS_ADDR)       ? statusImage : 8'h00;

    sink_limit_decode u_limit
    (
        .code  (sinkLimitSelect_reg),
        .limit (limitDecoded)
    );

    guard_timer #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) u_guard
    (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .run      (guardCount),
        .countEn  (guardCount),
        .rateFast (guardRateSelect_reg), // [RULE18]
        .restart  (guardRestart),
        .expire   (guardExpire)
    );

    // control registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            powerStageEnable_reg <= 1'b0;
            slewSelect_reg       <= 2'h0;
            switchedSupplyOn_reg <= 1'b0;
            sinkLimitSelect_reg  <= 3'h0;
            guardWakeEnable_reg  <= 1'b0;
            guardRateSelect_reg  <= 1'b0;
        end
        else
        begin
            if (wrCtl)
            begin
                powerStageEnable_reg <= req.wdata[power_stage_pkg::PSE_BIT]; // [RULE5]
                slewSelect_reg <= {req.wdata[power_stage_pkg::SLEWH_BIT],
                                   req.wdata[power_stage_pkg::SLEWL_BIT]}; // [RULE6]
            end
            if (wrPout)
                switchedSupplyOn_reg <= req.wdata[power_stage_pkg::SWON_BIT];
            if (wrLimit)
                sinkLimitSelect_reg <= req.wdata[power_stage_pkg::LIM_LSB +: 3]; // [RULE1]
            if (wrGuard)
            begin
                guardWakeEnable_reg <= req.wdata[power_stage_pkg::GIE_BIT];
                guardRateSelect_reg <= req.wdata[power_stage_pkg::GRATE_BIT]; // [RULE18]
            end
        end
    end

    // write-once reset enable
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            guardResetEnable_reg <= 1'b0;
        else if (wrGuard && req.wdata[power_stage_pkg::GRE_BIT])
            guardResetEnable_reg <= 1'b1; // [RULE13]
    end

    // stop request: set by write, cleared by cpu interrupt
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            stopRequest_reg <= 1'b0;
        else if (stopSet)
            stopRequest_reg <= 1'b1; // [RULE7]
        else if (cpuIrq)
            stopRequest_reg <= 1'b0; // [RULE7]
    end

    // sticky over-current flags, set wins over clear
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            supplyOcFlag_reg <= 1'b0;
            bridgeOcFlag_reg <= 1'b0;
        end
        else
        begin
            supplyOcFlag_reg <= supplyFault || (supplyOcFlag_reg && !supplyOcClr); // [RULE4] [RULE21]
            bridgeOcFlag_reg <= bridgeOvercurrent || (bridgeOcFlag_reg && !bridgeOcClr); // [RULE11] [RULE21]
        end
    end

    // registered outputs
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rdata                <= 8'h00;
            switchedSupplyOutput <= 1'b0;
            bridgeEnable         <= 1'b0;
            linTxEnable          <= 1'b0;
            sinkLimit            <= power_stage_pkg::LIM_NONE;
            linSlew              <= power_stage_pkg::SLEW_INITIAL_20K;
            stopMode             <= 1'b0;
            guardOscRun          <= 1'b0;
            guardResetOut        <= 1'b0;
            guardWakeIrq         <= 1'b0;
        end
        else
        begin
            rdata <= req.rd ? readMux : 8'h00;
            switchedSupplyOutput <= powerStageEnable_reg && switchedSupplyOn_reg
                                    && !supplyOcFlag_reg && !supplyFault; // [RULE2] [RULE4]
            bridgeEnable  <= powerStageEnable_reg && !bridgeOcFlag_reg
                             && !bridgeOvercurrent; // [RULE5] [RULE11]
            linTxEnable   <= powerStageEnable_reg; // [RULE5]
            sinkLimit     <= limitDecoded; // [RULE1]
            linSlew       <= power_stage_pkg::slew_t'(slewSelect_reg); // [RULE6]
            stopMode      <= stopRequest_reg; // [RULE7]
            guardOscRun   <= guardCount; // [RULE12]
            guardResetOut <= guardExpire && guardResetEnable_reg && !stopRequest_reg; // [RULE14] [RULE15]
            guardWakeIrq  <= guardExpire && guardWakeEnable_reg && stopRequest_reg; // [RULE17]
        end
    end

    // assertions
    property p_supply_gate;
        @(posedge mclk) disable iff (sys_rst)
        switchedSupplyOutput |-> $past(powerStageEnable_reg) && $past(switchedSupplyOn_reg);
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("supply on without enables"); // [RULE2]

    property p_supply_oc_sticky;
        @(posedge mclk) disable iff (sys_rst)
        supplyOcFlag_reg && !supplyOcClr |=> supplyOcFlag_reg;
    endproperty
    a_supply_oc_sticky: assert property (p_supply_oc_sticky) else $error("supply flag lost"); // [RULE21]

    property p_supply_oc_set;
        @(posedge mclk) disable iff (sys_rst)
        supplyOvercurrent |=> supplyOcFlag_reg ##1 !switchedSupplyOutput;
    endproperty
    a_supply_oc_set: assert property (p_supply_oc_set) else $error("supply fault not latched"); // [RULE4]

    property p_bridge_clear;
        @(posedge mclk) disable iff (sys_rst)
        bridgeOcClr && !bridgeOvercurrent |=> !bridgeOcFlag_reg;
    endproperty
    a_bridge_clear: assert property (p_bridge_clear) else $error("bridge flag not cleared"); // [RULE11]

    property p_write_once;
        @(posedge mclk) disable iff (sys_rst)
        guardResetEnable_reg |=> guardResetEnable_reg;
    endproperty
    a_write_once: assert property (p_write_once) else $error("reset enable cleared"); // [RULE13]

    property p_reset_not_in_stop;
        @(posedge mclk) disable iff (sys_rst)
        guardResetOut |-> $past(!stopRequest_reg) && $past(guardResetEnable_reg);
    endproperty
    a_reset_not_in_stop: assert property (p_reset_not_in_stop) else $error("reset in stop"); // [RULE15]

    property p_wake_in_stop;
        @(posedge mclk) disable iff (sys_rst)
        guardWakeIrq |-> $past(stopRequest_reg) && $past(guardWakeEnable_reg);
    endproperty
    a_wake_in_stop: assert property (p_wake_in_stop) else $error("wake outside stop"); // [RULE17]

    property p_stop_set;
        @(posedge mclk) disable iff (sys_rst)
        stopSet |=> ##1 stopMode;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop not entered"); // [RULE7]

    property p_osc_off;
        @(posedge mclk) disable iff (sys_rst)
        !guardResetEnable_reg && !guardWakeEnable_reg |=> !guardOscRun && !guardResetOut;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("timer runs while disabled"); // [RULE12]

    property p_restart_reads_zero;
        @(posedge mclk) disable iff (sys_rst)
        rd && addr == power_stage_pkg::GUARD_TIMER_CONTROL_ADDR |=> !rdata[power_stage_pkg::GRST_BIT];
    endproperty
    a_restart_reads_zero: assert property (p_restart_reads_zero) else $error("restart reads one"); // [RULE16]

    property p_lin_gate;
        @(posedge mclk) disable iff (sys_rst)
        linTxEnable |-> $past(powerStageEnable_reg);
    endproperty
    a_lin_gate: assert property (p_lin_gate) else $error("lin on without enable"); // [RULE5]

    property p_bridge_gate;
        @(posedge mclk) disable iff (sys_rst)
        bridgeEnable |-> $past(powerStageEnable_reg) && !$past(bridgeOcFlag_reg);
    endproperty
    a_bridge_gate: assert property (p_bridge_gate) else $error("bridge on while blocked"); // [RULE11]

    property p_bridge_oc_sticky;
        @(posedge mclk) disable iff (sys_rst)
        bridgeOcFlag_reg && !bridgeOcClr |=> bridgeOcFlag_reg;
    endproperty
    a_bridge_oc_sticky: assert property (p_bridge_oc_sticky) else $error("bridge flag lost"); // [RULE21]

    property p_supply_clear;
        @(posedge mclk) disable iff (sys_rst)
        supplyOcClr && !supplyFault |=> !supplyOcFlag_reg;
    endproperty
    a_supply_clear: assert property (p_supply_clear) else $error("supply flag not cleared"); // [RULE9]

    property p_stop_clear;
        @(posedge mclk) disable iff (sys_rst)
        cpuIrq && !stopSet |=> !stopRequest_reg;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop kept after irq"); // [RULE7]

    property p_stop_mode;
        @(posedge mclk) disable iff (sys_rst)
        stopRequest_reg |=> stopMode;
    endproperty
    a_stop_mode: assert property (p_stop_mode) else $error("stop mode missing"); // [RULE7]

    property p_osc_on;
        @(posedge mclk) disable iff (sys_rst)
        guardResetEnable_reg || guardWakeEnable_reg |=> guardOscRun;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("timer stopped while enabled"); // [RULE12]

    property p_limit_none;
        @(posedge mclk) disable iff (sys_rst)
        sinkLimitSelect_reg < power_stage_pkg::LIMIT_FIRST_CODE
        |=> sinkLimit == power_stage_pkg::LIM_NONE;
    endproperty
    a_limit_none: assert property (p_limit_none) else $error("low code gives limit"); // [RULE1]

    property p_limit_top;
        @(posedge mclk) disable iff (sys_rst)
        sinkLimitSelect_reg == 3'h7 |=> sinkLimit == power_stage_pkg::LIM_740MA;
    endproperty
    a_limit_top: assert property (p_limit_top) else $error("top code wrong limit"); // [RULE1]

    property p_status_mirror;
        @(posedge mclk) disable iff (sys_rst)
        rd && addr == power_stage_pkg::SYSTEM_STATUS_ADDR
        |=> rdata[power_stage_pkg::LV_BIT] == $past(lowVoltageFlag)
            && rdata[power_stage_pkg::OT_BIT] == $past(overtempFlag);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("mirror bits wrong"); // [RULE10]

    property p_lin_limit_status;
        @(posedge mclk) disable iff (sys_rst)
        rd && addr == power_stage_pkg::SYSTEM_STATUS_ADDR
        |=> rdata[power_stage_pkg::LINL_BIT] == $past(linTxLimiting);
    endproperty
    a_lin_limit_status: assert property (p_lin_limit_status) else $error("lin limit bit wrong"); // [RULE8]

    c_guard_reset: cover property (@(posedge mclk) disable iff (sys_rst) guardResetOut);
    c_guard_wake:  cover property (@(posedge mclk) disable iff (sys_rst) guardWakeIrq);
    c_oc_clear:    cover property (@(posedge mclk) disable iff (sys_rst)
                                   supplyOcFlag_reg ##1 supplyOcClr ##1 !supplyOcFlag_reg);
    c_stop_entry:  cover property (@(posedge mclk) disable iff (sys_rst) stopSet ##2 stopMode);
    c_restart:     cover property (@(posedge mclk) disable iff (sys_rst) guardRestart);
endmodule

// >>> testbench/power_stage_control_tb_top.sv
// power_stage_control_tb_top: self-checking bench for the power stage register bank
// assumes shortened guard timer periods and a bench-driven strobe register port
`timescale 1ns/1ps
module power_stage_control_tb_top;
    localparam int FAST = 20;
    localparam int SLOW = 40;
    logic       mclk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       supOc = 1'b0, brOc = 1'b0, supOt = 1'b0, htRe = 1'b0, linLim = 1'b0;
    logic       low_voltage_flag = 1'b0, high_voltage_flag = 1'b0, otF = 1'b0, cpuIrq = 1'b0;
    logic       supOut, brEn, linEn, stopMode, oscRun, rstOut, wakeIrq;
    power_stage_pkg::sink_limit_t sinkLimit;
    power_stage_pkg::slew_t       linSlew;
    int         n_fail = 0, cmp_count = 0, resetCount = 0, wakeCount = 0;
    logic [7:0] d;
    int         cyc;

    power_stage_control #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .supplyOvercurrent(supOc), .bridgeOvercurrent(brOc),
        .supplyOvertemp(supOt), .highTempResetEnable(htRe), .linTxLimiting(linLim),
        .lowVoltageFlag(low_voltage_flag), .highVoltageFlag(high_voltage_flag), .overtempFlag(otF), .cpuIrq(cpuIrq),
        .switchedSupplyOutput(supOut), .bridgeEnable(brEn), .linTxEnable(linEn),
        .sinkLimit(sinkLimit), .linSlew(linSlew), .stopMode(stopMode),
        .guardOscRun(oscRun), .guardResetOut(rstOut), .guardWakeIrq(wakeIrq));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (rstOut === 1'b1) resetCount <= resetCount + 1;
        if (wakeIrq === 1'b1) wakeCount <= wakeCount + 1;
    end

    task report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        rd <= 1'b1; addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // waits for a guard pulse; a spent bound is a mismatch and ends the run
    task wait_pulse(input bit useWake, input int bound, output int n);
        int start;
        start = useWake ? wakeCount : resetCount;
        n = 0;
        while ((useWake ? wakeCount : resetCount) == start && n < bound)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= bound)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task t_reset_values();
        logic [7:0] regs [6];
        regs = '{8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c, 8'h07};
        foreach (regs[i])
        begin
            rd_reg(regs[i], d);
            check(d, 8'h00);
        end
        check({supOut, brEn, linEn, stopMode, oscRun, rstOut, wakeIrq}, 8'h00);
        wr_reg(8'h07, 8'hff);
        rd_reg(8'h07, d);
        check(d, 8'h00);
    endtask

    task t_limits();
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h02, 8'(c));
            tick(3);
            check(8'(sinkLimit), (c < 3) ? 8'h00 : 8'(c - 2));
        end
    endtask

    task t_power();
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(8'h03, 8'(s << 5));
            tick(3);
            check(8'(linSlew), 8'(s));
            rd_reg(8'h03, d);
            check(d, 8'(s << 5));
        end
        wr_reg(8'h0b, 8'h02);
        tick(3);
        check({supOut, brEn, linEn}, 8'h00);
        wr_reg(8'h03, 8'h80);
        tick(3);
        check({supOut, brEn, linEn}, 8'h07);
        wr_reg(8'h0b, 8'h00);
        tick(3);
        check({supOut, brEn, linEn}, 8'h03);
        wr_reg(8'h0b, 8'h02);
    endtask

    task t_faults();
        @(posedge mclk) supOc <= 1'b1;
        @(posedge mclk) supOc <= 1'b0;
        tick(3);
        check(supOut, 1'b0);
        rd_reg(8'h0c, d);
        check(d, 8'h20);
        wr_reg(8'h0c, 8'h00);
        rd_reg(8'h0c, d);
        check(d, 8'h20);
        wr_reg(8'h0c, 8'h20);
        tick(3);
        check(supOut, 1'b1);
        @(posedge mclk) brOc <= 1'b1;
        @(posedge mclk) brOc <= 1'b0;
        tick(3);
        rd_reg(8'h0c, d);
        check({d, brEn}, 9'h004);
        wr_reg(8'h0c, 8'h02);
        tick(3);
        rd_reg(8'h0c, d);
        check({d, brEn}, 9'h001);
        @(posedge mclk) supOt <= 1'b1;
        tick(4);
        check(supOut, 1'b1);
        @(posedge mclk) htRe <= 1'b1;
        tick(4);
        check(supOut, 1'b0);
        @(posedge mclk) supOt <= 1'b0;
        wr_reg(8'h0c, 8'h20);
        tick(3);
        check(supOut, 1'b1);
    endtask

    task t_mirrors();
        logic [3:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = 4'h1 << i;
            @(posedge mclk) {linLim, low_voltage_flag, high_voltage_flag, otF} <= v;
            wr_reg(8'h0c, 8'h00);
            rd_reg(8'h0c, d);
            check(d, {1'b0, v[3], 2'b00, v[2], v[1], 1'b0, v[0]});
            check(supOut, 1'b1);
        end
        @(posedge mclk) {linLim, low_voltage_flag, high_voltage_flag, otF} <= 4'h0;
    endtask

    task t_wake();
        wr_reg(8'h0a, 8'h08);
        tick(3);
        check(oscRun, 1'b1);
        wr_reg(8'h03, 8'h81);
        tick(2);
        check(stopMode, 1'b1);
        wait_pulse(1'b1, 3 * SLOW, cyc);
        @(posedge mclk) cpuIrq <= 1'b1;
        @(posedge mclk) cpuIrq <= 1'b0;
        tick(2);
        check(stopMode, 1'b0);
        cyc = wakeCount;
        tick(3 * SLOW);
        check(8'(wakeCount - cyc), 8'h00);
        check(8'(resetCount), 8'h00);
        wr_reg(8'h0a, 8'h00);
        tick(3);
        check(oscRun, 1'b0);
    endtask

    task t_guard();
        wr_reg(8'h0a, 8'h31);
        wr_reg(8'h0a, 8'h01);
        rd_reg(8'h0a, d);
        check(d, 8'h11);
        wr_reg(8'h0a, 8'h31);
        wait_pulse(1'b0, 3 * FAST, cyc);
        check(cyc > FAST - 5 && cyc < FAST + 5, 1'b1);
        wr_reg(8'h0a, 8'h30);
        wait_pulse(1'b0, 3 * SLOW, cyc);
        check(cyc > SLOW - 5 && cyc < SLOW + 5, 1'b1);
        cyc = resetCount;
        repeat (8) wr_reg(8'h0a, 8'h30);
        check(8'(resetCount - cyc), 8'h00);
        wr_reg(8'h03, 8'h01);
        cyc = resetCount;
        tick(3 * SLOW);
        check(8'(resetCount - cyc), 8'h00);
        @(posedge mclk) cpuIrq <= 1'b1;
        @(posedge mclk) cpuIrq <= 1'b0;
        wait_pulse(1'b0, 3 * SLOW, cyc);
        check(stopMode, 1'b0);
    endtask

    initial
    begin
        tick(4);
        @(posedge mclk) sys_rst <= 1'b0; // trim byte copy is done outside this bank
        t_reset_values();
        t_limits();
        t_power();
        t_faults();
        t_mirrors();
        t_wake();
        t_guard();
        report_and_stop();
    end
endmodule
